// ===== dram_bank_pkg.sv
package dram_bank_pkg;

  // ==========================================================
  // bus transfer sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ==========================================================
  // address split: column is the word address inside a page
  localparam int COL_LSB   = 2;
  localparam int ROW_LSB   = 12;
  localparam int BANK_BIT  = 27;
  localparam logic [7:0] BURST_EDGE = 8'hff;

  // ==========================================================
  // cycle counts (loaded as count minus one)
  localparam logic [3:0] CAS_CYCLES     = 4'h2;
  localparam logic [3:0] PRE_CYCLES     = 4'h2;
  localparam logic [3:0] REF_RAS_CYCLES = 4'h3;

  // ==========================================================
  // controller states
  typedef enum logic [13:0] {
    ST_IDLE    = 14'h0001,
    ST_ROW     = 14'h0002,
    ST_COL     = 14'h0004,
    ST_CAS     = 14'h0008,
    ST_DONE    = 14'h0010,
    ST_PAGE    = 14'h0020,
    ST_PRE     = 14'h0040,
    ST_REF_CAS = 14'h0080,
    ST_REF_RAS = 14'h0100,
    ST_SR_CAS  = 14'h0200,
    ST_SR_RAS  = 14'h0400,
    ST_LOW     = 14'h0800,
    ST_LP_RESP = 14'h1000,
    ST_SR_EXIT = 14'h2000
  } state_e;

  // ==========================================================
  // whole controller state, outputs included
  typedef struct packed {
    state_e      st;
    logic [3:0]  cnt;
    logic [9:0]  col;
    logic [12:0] row;
    logic        bank;
    logic [3:0]  lanes;
    logic        wr;
    logic        self_ref;
    logic [3:0]  fb_meta;
    logic [3:0]  fb_sync;
    logic [7:0]  ref_pre;
    logic [6:0]  ref_cnt;
    logic        ref_pend;
    logic        bus_wait;
    logic        bus_error;
    logic        bus_last;
    logic [1:0]  row_strobe_n;
    logic [3:0]  column_strobe_n;
    logic        mem_output_enable_n;
    logic        mem_write_enable_n;
    logic        power_down_acknowledge;
    logic        address_mux_select;
    logic        address_latch_open_n;
    logic [12:0] mem_mux_address;
    logic        read_driver_enable_n;
    logic [3:0]  read_latch_enable_n;
    logic        write_driver_enable_n;
    logic        write_latch_enable_n;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{
    st: ST_IDLE,
    row_strobe_n: 2'h3,
    column_strobe_n: 4'hf,
    mem_output_enable_n: 1'b1,
    mem_write_enable_n: 1'b1,
    address_latch_open_n: 1'b1,
    read_driver_enable_n: 1'b1,
    write_latch_enable_n: 1'b1,
    default: '0
  };

endpackage

// ===== dram_bank_controller.sv
`timescale 1ns/1ns
module dram_bank_controller (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [27:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic [1:0]  bus_size,
  input  wire logic        bus_seq,
  input  wire logic        memory_space_select,
  input  wire logic        config_register_select,
  input  wire logic        big_endian,
  input  wire logic        refresh_enable,
  input  wire logic [6:0]  refresh_rate,
  input  wire logic [7:0]  refresh_clock_div,
  input  wire logic        power_down_request,
  input  wire logic [3:0]  column_strobe_feedback,
  output logic             bus_wait,
  output logic             bus_error,
  output logic             bus_last,
  output logic [1:0]       row_strobe_n,
  output logic [3:0]       column_strobe_n,
  output logic             mem_output_enable_n,
  output logic             mem_write_enable_n,
  output logic             power_down_acknowledge,
  output logic             address_mux_select,
  output logic             address_latch_open_n,
  output logic [12:0]      mem_mux_address,
  output logic             read_driver_enable_n,
  output logic [3:0]       read_latch_enable_n,
  output logic             write_driver_enable_n,
  output logic             write_latch_enable_n
);

  // ==========================================================
  // helpers

  // lane mask from size and low address; big-endian mirrors the lanes
  function automatic logic [3:0] lane_mask(
    input logic [1:0] size,
    input logic [1:0] low,
    input logic       be
  );
    logic [1:0] a;
    a = low ^ {be, be};
    if (size == dram_bank_pkg::SIZE_BYTE)
      lane_mask = 4'h1 << a;
    else if (size == dram_bank_pkg::SIZE_HALF)
      lane_mask = a[1] ? 4'hc : 4'h3;
    else
      lane_mask = 4'hf; // word (and the unused code) strobes every lane
  endfunction

  // row strobe pattern for the open bank
  function automatic logic [1:0] bank_ras(input logic bank);
    bank_ras = bank ? 2'h1 : 2'h2;
  endfunction

  dram_bank_pkg::ctrl_s s;
  dram_bank_pkg::ctrl_s n;
  logic                 sel;
  logic                 page_hit;
  logic                 tick;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // ==========================================================
  // next-state logic
  always_comb
  begin
    n = s;
    sel = memory_space_select | config_register_select; // decoder selects only
    page_hit = bus_seq && (bus_addr[dram_bank_pkg::BANK_BIT] == s.bank)
               && (bus_addr[dram_bank_pkg::ROW_LSB +: 13] == s.row);
    tick = 1'b0;
    n.bus_error = 1'b0;
    n.bus_last = 1'b0;
    // feedback from the pads crosses in through two flops
    n.fb_meta = column_strobe_feedback;
    n.fb_sync = s.fb_meta;

    // main sequencer
    unique case (s.st)
      dram_bank_pkg::ST_IDLE:
      begin
        if (power_down_request)
        begin
          n.self_ref = refresh_enable; // self-refresh only with refresh on
          n.st = refresh_enable ? dram_bank_pkg::ST_SR_CAS : dram_bank_pkg::ST_LOW;
        end
        else if (s.ref_pend)
          n.st = dram_bank_pkg::ST_REF_CAS; // refresh wins over a waiting access
        else if (memory_space_select)
        begin
          n.st = dram_bank_pkg::ST_ROW;
          n.wr = bus_write;
          n.lanes = lane_mask(bus_size, bus_addr[1:0], big_endian);
          n.row = bus_addr[dram_bank_pkg::ROW_LSB +: 13];
          n.bank = bus_addr[dram_bank_pkg::BANK_BIT];
          n.col = bus_addr[dram_bank_pkg::COL_LSB +: 10];
        end
        else if (config_register_select)
          n.st = dram_bank_pkg::ST_DONE; // register access answers at once
      end
      dram_bank_pkg::ST_ROW:
        n.st = dram_bank_pkg::ST_COL;
      dram_bank_pkg::ST_COL:
      begin
        n.st = dram_bank_pkg::ST_CAS;
        n.cnt = dram_bank_pkg::CAS_CYCLES - 4'h1;
      end
      dram_bank_pkg::ST_CAS:
      begin
        if (s.cnt != 4'h0)
          n.cnt = s.cnt - 4'h1;
        else if ((s.fb_sync & s.lanes) == 4'h0) // strobes really low at the pads
        begin
          n.st = dram_bank_pkg::ST_DONE;
          n.bus_last = (s.col[7:0] == dram_bank_pkg::BURST_EDGE);
        end
      end
      dram_bank_pkg::ST_DONE:
      begin
        // a boundary or pending work closes the page
        if (s.bus_last || s.ref_pend || power_down_request)
        begin
          n.st = dram_bank_pkg::ST_PRE;
          n.cnt = dram_bank_pkg::PRE_CYCLES - 4'h1;
        end
        else
          n.st = dram_bank_pkg::ST_PAGE;
        if (s.row_strobe_n == 2'h3)
          n.st = dram_bank_pkg::ST_IDLE; // register access had no row open
      end
      dram_bank_pkg::ST_PAGE:
      begin
        if (s.ref_pend || power_down_request || (memory_space_select && !page_hit))
        begin
          n.st = dram_bank_pkg::ST_PRE;
          n.cnt = dram_bank_pkg::PRE_CYCLES - 4'h1;
        end
        else if (memory_space_select)
        begin
          n.st = dram_bank_pkg::ST_COL; // row stays open, next column
          n.col = s.col + 10'h1;
          n.wr = bus_write;
          n.lanes = lane_mask(bus_size, bus_addr[1:0], big_endian);
        end
        else if (config_register_select)
          n.st = dram_bank_pkg::ST_DONE;
      end
      dram_bank_pkg::ST_PRE, dram_bank_pkg::ST_SR_EXIT:
      begin
        if (s.cnt == 4'h0)
          n.st = dram_bank_pkg::ST_IDLE;
        else
          n.cnt = s.cnt - 4'h1;
      end
      dram_bank_pkg::ST_REF_CAS:
      begin
        n.st = dram_bank_pkg::ST_REF_RAS; // column strobes lead the row strobes
        n.cnt = dram_bank_pkg::REF_RAS_CYCLES - 4'h1;
        n.ref_pend = 1'b0;
      end
      dram_bank_pkg::ST_REF_RAS:
      begin
        if (s.cnt == 4'h0)
        begin
          n.st = dram_bank_pkg::ST_PRE;
          n.cnt = dram_bank_pkg::PRE_CYCLES - 4'h1;
        end
        else
          n.cnt = s.cnt - 4'h1;
      end
      dram_bank_pkg::ST_SR_CAS:
        n.st = dram_bank_pkg::ST_SR_RAS;
      dram_bank_pkg::ST_SR_RAS:
        n.st = dram_bank_pkg::ST_LOW; // entry complete, acknowledge follows
      dram_bank_pkg::ST_LOW:
      begin
        if (!power_down_request)
        begin
          n.st = dram_bank_pkg::ST_SR_EXIT;
          n.cnt = dram_bank_pkg::PRE_CYCLES - 4'h1;
          n.self_ref = 1'b0;
        end
        else if (sel)
        begin
          n.st = dram_bank_pkg::ST_LP_RESP;
          n.bus_error = memory_space_select; // no access while powered down
        end
      end
      dram_bank_pkg::ST_LP_RESP:
        n.st = dram_bank_pkg::ST_LOW;
    endcase

    // refresh clock divider and 7-bit down counter
    if (refresh_enable && refresh_clock_div != 8'h00)
    begin
      if (s.ref_pre == 8'h00)
      begin
        n.ref_pre = refresh_clock_div - 8'h1;
        tick = 1'b1;
      end
      else
        n.ref_pre = s.ref_pre - 8'h1;
    end
    if (tick)
    begin
      if (s.ref_cnt == 7'h00)
      begin
        n.ref_cnt = refresh_rate; // reload after each request
        if (refresh_rate != 7'h00)
          n.ref_pend = 1'b1; // set wins over the clear above
      end
      else
        n.ref_cnt = s.ref_cnt - 7'h1;
    end

    // responses only toward a selecting master; quiet the cycle after done
    n.bus_wait = sel && !(n.st inside {dram_bank_pkg::ST_DONE, dram_bank_pkg::ST_LP_RESP})
                 && !(s.st inside {dram_bank_pkg::ST_DONE, dram_bank_pkg::ST_LP_RESP});
    n.bus_error = n.bus_error && memory_space_select;
    n.bus_last = n.bus_last && memory_space_select;

    // pin values follow the next state, so every pin is a flop
    n.address_mux_select = n.st inside {dram_bank_pkg::ST_ROW, dram_bank_pkg::ST_COL,
                                        dram_bank_pkg::ST_CAS};
    n.address_latch_open_n = !n.address_mux_select;
    if (n.st == dram_bank_pkg::ST_ROW)
      n.mem_mux_address = n.row; // row first
    else if (n.st inside {dram_bank_pkg::ST_COL, dram_bank_pkg::ST_CAS})
      n.mem_mux_address = {3'h0, n.col}; // then column
    if (n.st inside {dram_bank_pkg::ST_ROW, dram_bank_pkg::ST_COL, dram_bank_pkg::ST_CAS,
                     dram_bank_pkg::ST_DONE, dram_bank_pkg::ST_PAGE} && s.st != dram_bank_pkg::ST_IDLE
        || n.st == dram_bank_pkg::ST_ROW)
      n.row_strobe_n = bank_ras(n.bank); // held low across the page
    else if (n.st inside {dram_bank_pkg::ST_REF_RAS, dram_bank_pkg::ST_SR_RAS}
             || (n.st inside {dram_bank_pkg::ST_LOW, dram_bank_pkg::ST_LP_RESP} && n.self_ref))
      n.row_strobe_n = 2'h0;
    else
      n.row_strobe_n = 2'h3;
    if (n.st == dram_bank_pkg::ST_DONE && s.st == dram_bank_pkg::ST_IDLE)
      n.row_strobe_n = 2'h3; // register access touches no bank
    if (n.st == dram_bank_pkg::ST_CAS)
      n.column_strobe_n = ~n.lanes;
    else if (n.st inside {dram_bank_pkg::ST_REF_CAS, dram_bank_pkg::ST_REF_RAS,
                          dram_bank_pkg::ST_SR_CAS, dram_bank_pkg::ST_SR_RAS}
             || (n.st inside {dram_bank_pkg::ST_LOW, dram_bank_pkg::ST_LP_RESP} && n.self_ref))
      n.column_strobe_n = 4'h0;
    else
      n.column_strobe_n = 4'hf;
    n.mem_write_enable_n = !(n.st == dram_bank_pkg::ST_CAS && n.wr);
    // output enable held into done: extended-data-out keeps data valid
    n.mem_output_enable_n = !(n.st inside {dram_bank_pkg::ST_CAS, dram_bank_pkg::ST_DONE}
                              && !n.wr && n.row_strobe_n != 2'h3);
    n.read_driver_enable_n = n.mem_output_enable_n;
    n.read_latch_enable_n = (!n.mem_output_enable_n && n.st == dram_bank_pkg::ST_DONE)
                            ? n.lanes : 4'h0;
    n.write_driver_enable_n = !n.wr && n.st inside {dram_bank_pkg::ST_ROW, dram_bank_pkg::ST_COL,
                                                     dram_bank_pkg::ST_CAS, dram_bank_pkg::ST_DONE};
    n.write_latch_enable_n = !(n.wr && n.address_mux_select);
    n.power_down_acknowledge = n.st inside {dram_bank_pkg::ST_LOW, dram_bank_pkg::ST_LP_RESP};
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s <= dram_bank_pkg::CTRL_RESET;
    else
      s <= n;
  end

  // outputs straight from the state flops
  assign bus_wait               = s.bus_wait;
  assign bus_error              = s.bus_error;
  assign bus_last               = s.bus_last;
  assign row_strobe_n           = s.row_strobe_n;
  assign column_strobe_n        = s.column_strobe_n;
  assign mem_output_enable_n    = s.mem_output_enable_n;
  assign mem_write_enable_n     = s.mem_write_enable_n;
  assign power_down_acknowledge = s.power_down_acknowledge;
  assign address_mux_select     = s.address_mux_select;
  assign address_latch_open_n   = s.address_latch_open_n;
  assign mem_mux_address        = s.mem_mux_address;
  assign read_driver_enable_n   = s.read_driver_enable_n;
  assign read_latch_enable_n    = s.read_latch_enable_n;
  assign write_driver_enable_n  = s.write_driver_enable_n;
  assign write_latch_enable_n   = s.write_latch_enable_n;

  // ==========================================================
  // checks
  lp_error_a: assert property (
    s.st == dram_bank_pkg::ST_LOW && power_down_request && memory_space_select
    |=> s.bus_error && !s.bus_wait)
    else $error("no error answer in low power");
  burst_last_a: assert property (
    s.st == dram_bank_pkg::ST_CAS && n.st == dram_bank_pkg::ST_DONE && memory_space_select
    && s.col[7:0] == dram_bank_pkg::BURST_EDGE |=> s.bus_last ##1 s.st == dram_bank_pkg::ST_PRE)
    else $error("boundary not flagged");
  wait_hold_a: assert property (
    s.st inside {dram_bank_pkg::ST_COL, dram_bank_pkg::ST_CAS} && memory_space_select |-> s.bus_wait)
    else $error("wait dropped mid transaction");
  resp_sel_a: assert property (
    (s.bus_error || s.bus_last) |-> $past(memory_space_select))
    else $error("response without select");
  word_lanes_a: assert property (
    s.st == dram_bank_pkg::ST_IDLE && !s.ref_pend && !power_down_request && memory_space_select
    && bus_size == dram_bank_pkg::SIZE_WORD |-> ##3 s.column_strobe_n == 4'h0)
    else $error("word access missed a lane");
  ack_state_a: assert property (
    $rose(s.power_down_acknowledge) |-> $past(s.st) inside {dram_bank_pkg::ST_IDLE,
                                                        dram_bank_pkg::ST_SR_RAS})
    else $error("acknowledge before entry complete");
  idle_pins_a: assert property (
    s.st == dram_bank_pkg::ST_IDLE |-> !s.address_mux_select && s.address_latch_open_n
    && s.write_latch_enable_n)
    else $error("shared interface held while idle");
  drivers_a: assert property (
    !s.read_driver_enable_n |-> s.write_driver_enable_n && s.read_latch_enable_n == 4'h0
    || s.read_latch_enable_n == s.lanes)
    else $error("both data directions driven");
  cbr_order_a: assert property (
    s.st == dram_bank_pkg::ST_REF_CAS |-> s.column_strobe_n == 4'h0 && s.row_strobe_n == 2'h3
    ##1 s.row_strobe_n == 2'h0 [*3])
    else $error("refresh strobe order wrong");
  page_ras_a: assert property (
    s.st == dram_bank_pkg::ST_PAGE |-> s.row_strobe_n != 2'h3 && $stable(s.row))
    else $error("row closed inside page");

  refresh_c: cover property (s.st == dram_bank_pkg::ST_REF_CAS ##4 s.st == dram_bank_pkg::ST_PRE);
  page_hit_c: cover property (s.st == dram_bank_pkg::ST_PAGE ##1 s.st == dram_bank_pkg::ST_COL);
  lp_error_c: cover property (s.bus_error);
  last_c: cover property (s.bus_last);

endmodule

// ===== dram_pad_model.sv
`timescale 1ns/1ns
module dram_pad_model (
  input  wire logic       clk_sys,
  input  wire logic       slow,
  input  wire logic [3:0] column_strobe_n,
  output logic [3:0]      column_strobe_feedback
);
  logic [3:0] pad_d1;
  logic [3:0] pad_d2;

  // ==========================================================
  // pad and board lag; the slow setting delays each strobe by two cycles
  always_ff @(posedge clk_sys)
  begin
    pad_d1 <= column_strobe_n;
    pad_d2 <= pad_d1;
  end
  assign column_strobe_feedback = slow ? pad_d2 : column_strobe_n;
endmodule

// ===== tb_dram_bank_controller.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t value mismatch", $time); end end
module tb_dram_bank_controller;
  logic        clk_sys, nrst, bus_write, bus_seq, memory_space_select, config_register_select;
  logic        big_endian, refresh_enable, power_down_request, slow;
  logic [27:0] bus_addr;
  logic [1:0]  bus_size, row_strobe_n;
  logic [6:0]  refresh_rate;
  logic [7:0]  refresh_clock_div;
  logic [3:0]  column_strobe_feedback, column_strobe_n, read_latch_enable_n;
  logic        bus_wait, bus_error, bus_last, mem_output_enable_n, mem_write_enable_n;
  logic        power_down_acknowledge, address_mux_select, address_latch_open_n;
  logic        read_driver_enable_n, write_driver_enable_n, write_latch_enable_n, cbr_seen;
  logic [12:0] mem_mux_address;
  logic [12:0] col_q[$];
  int          fails, check_count, seed, n;

  dram_bank_controller uut (.clk_sys, .nrst, .bus_addr, .bus_write, .bus_size, .bus_seq,
    .memory_space_select, .config_register_select, .big_endian, .refresh_enable, .refresh_rate,
    .refresh_clock_div, .power_down_request, .column_strobe_feedback, .bus_wait, .bus_error,
    .bus_last, .row_strobe_n, .column_strobe_n, .mem_output_enable_n, .mem_write_enable_n,
    .power_down_acknowledge, .address_mux_select, .address_latch_open_n, .mem_mux_address,
    .read_driver_enable_n, .read_latch_enable_n, .write_driver_enable_n, .write_latch_enable_n);

  dram_pad_model pads (.clk_sys, .slow, .column_strobe_n, .column_strobe_feedback);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // reference lane decode, built from size and low address bits
  function automatic logic [3:0] lane_mask(input logic [1:0] sz, input logic [1:0] a, input logic be);
    logic [1:0] l;
    l = a ^ {be, be};
    if (sz == 2'h0) return 4'h1 << l;
    if (sz == 2'h1) return l[1] ? 4'hc : 4'h3;
    return 4'hf;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one bus transfer held until completion; control pins sampled every busy cycle
  task automatic access(input logic [27:0] a, input logic w, input logic [1:0] sz, input logic sq,
                        input logic rsel, input logic err);
    logic [3:0]  cas_and;
    logic [12:0] row_seen;
    logic        ras_prev;
    logic        bad;
    int          k;
    bus_addr = a;
    bus_write = w;
    bus_size = sz;
    bus_seq = sq;
    if (!rsel && !err)
      col_q.push_back({3'h0, a[11:2]}); // reference model: column the beat must end on
    memory_space_select = !rsel;
    config_register_select = rsel;
    cas_and = 4'hf;
    row_seen = a[24:12];
    bad = 1'b0;
    k = 0;
    ras_prev = row_strobe_n[a[27]];
    @(posedge clk_sys);
    #1;
    while (bus_wait === 1'b1 && k < 60)
    begin
      cas_and &= column_strobe_n;
      if (ras_prev && !row_strobe_n[a[27]]) row_seen = mem_mux_address;
      ras_prev = row_strobe_n[a[27]];
      bad |= address_mux_select && (write_driver_enable_n !== ~w || write_latch_enable_n !== ~w);
      bad |= sq && row_strobe_n[a[27]];
      // while a column strobe is low the write and output enables must follow the direction
      bad |= column_strobe_n !== 4'hf && (mem_write_enable_n !== ~w || mem_output_enable_n !== w);
      @(posedge clk_sys);
      #1;
      k++;
    end
    `CHK(k < 60, 1'b1)
    `CHK(bus_error, err)
    `CHK(bus_last, sq && a[9:2] == 8'hff)
    `CHK(address_mux_select, 1'b0)
    if (!rsel && !err)
    begin
      `CHK(cas_and, ~lane_mask(sz, a[1:0], big_endian))
      `CHK(mem_mux_address, col_q.pop_front())
      `CHK(row_seen, a[24:12])
      `CHK(bad, 1'b0)
      `CHK(read_latch_enable_n, w ? 4'h0 : lane_mask(sz, a[1:0], big_endian))
      `CHK(read_driver_enable_n, w)
    end
    memory_space_select = 1'b0;
    config_register_select = 1'b0;
    bus_seq = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    #300000;
    fails++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {nrst, bus_write, bus_seq, memory_space_select, config_register_select, big_endian} = '0;
    {refresh_enable, power_down_request, slow, bus_addr, bus_size} = '0;
    refresh_rate = 7'h0;
    refresh_clock_div = 8'h0;
    seed = 32'hdf6e52d4;
    repeat (3) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    `CHK(row_strobe_n, 2'h3)
    `CHK(column_strobe_n, 4'hf)
    `CHK(address_latch_open_n, 1'b1)
    `CHK(power_down_acknowledge, 1'b0)
    // every size code, both byte orders, both directions; random address and bank
    for (int i = 0; i < 48; i++)
    begin
      big_endian = i[2];
      slow = i[0];
      access($random(seed) & 28'h8fffffb, i[3], i[1:0], 1'b0, 1'b0, 1'b0);
    end
    $display("test sizes done");
    // sequential beats up to the 256-word burst boundary (column 0x1ff)
    for (int i = 0; i < 3; i++)
      access({16'h0a52, 10'h1fd + 10'(i), 2'h0}, 1'b0, 2'h2, i > 0, 1'b0, 1'b0);
    access(28'h0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0);
    $display("test burst done");
    refresh_enable = 1'b1;
    refresh_rate = 7'h3;
    refresh_clock_div = 8'h2;
    cbr_seen = 1'b0;
    repeat (80)
    begin
      @(posedge clk_sys);
      #1;
      cbr_seen |= column_strobe_n === 4'h0 && row_strobe_n === 2'h3;
    end
    `CHK(cbr_seen, 1'b1)
    refresh_rate = 7'h0;
    refresh_clock_div = 8'h0;
    repeat (20) @(posedge clk_sys);
    #1;
    $display("test refresh done");
    power_down_request = 1'b1;
    for (n = 0; n < 40 && power_down_acknowledge !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(power_down_acknowledge, 1'b1)
    `CHK(column_strobe_n, 4'h0)
    `CHK(row_strobe_n, 2'h0)
    access(28'h0123450, 1'b1, 2'h2, 1'b0, 1'b0, 1'b1);
    access(28'h0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0);
    power_down_request = 1'b0;
    for (n = 0; n < 10 && power_down_acknowledge !== 1'b0; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(power_down_acknowledge, 1'b0)
    access(28'h8010200, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    $display("test power down done");
    stop_test();
  end
endmodule
